// [common/hsr_pkg.sv]
// constants shared by the four-bit shift register and its command FIFO
package hsr_pkg;
  localparam int HSR_WIDTH = 4;
  localparam int HSR_SYNC_STAGES = 3;
  localparam int HSR_FIFO_DEPTH = 16;
  // command word: {load_select, serial_in, parallel_in}
  localparam int HSR_CMD_W = HSR_WIDTH + 2;
  localparam int HSR_CMD_LOAD_BIT = HSR_WIDTH + 1;
  localparam int HSR_CMD_SER_BIT = HSR_WIDTH;
  // pin vector layout after synchronisation
  localparam int HSR_PIN_W = HSR_WIDTH + 4;
  localparam int HSR_PIN_CLK_BIT = HSR_WIDTH + 3;
  localparam int HSR_PIN_CMD_LSB = 1;
  localparam int HSR_PIN_OE_BIT = 0;
  // reset values
  localparam logic HSR_CLK_LVL_RST = 1'b1;
  localparam logic HSR_OE_LVL_RST = 1'b0;
  localparam logic [HSR_PIN_W-1:0] HSR_PIN_RST = 8'h80;
  localparam logic [HSR_WIDTH-1:0] HSR_OUT_RST = 4'h0;
endpackage

// [core/hsr_fifo.sv]
// parameterised flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module hsr_fifo #(
  parameter int W = 6,
  parameter int D = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem_q [D];
  logic [W-1:0] mem_d [D];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  assign in_ready = (cnt_q != (AW+1)'(D));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    mem_d = mem_q;
    wr_d = wr_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wr_q] = in_data;
      wr_d = (wr_q == AW'(D-1)) ? '0 : wr_q + 1'b1;
    end
    if (pop) begin
      rd_d = (rd_q == AW'(D-1)) ? '0 : rd_q + 1'b1;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  // storage needs no reset; only pointers and count are control state
  always_ff @(posedge clk) begin
    mem_q <= mem_d;
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  property p_no_overfill;
    @(posedge clk) disable iff (rst)
    cnt_q <= (AW+1)'(D);
  endproperty
  a_no_overfill: assert property (p_no_overfill)
    else $error("fifo count above depth");
endmodule

// [core/hsr_shift_reg.sv]
// four-bit shift register with parallel load and three-state outputs
`timescale 1ns/1ps
// Overview of operation
// - load_select high at a falling clock edge loads all stages in parallel.
// - load_select low shifts right, serial_in entering stage zero.
// - inputs sampled only at the falling edge; sender keeps them set up.
// - enable high drives outputs with the current stage contents, or with zero until the first command is applied.
// - enable low puts all four outputs in the off state.
// - output enable never affects loading or shifting.
module hsr_shift_reg
  import hsr_pkg::*;
#(
  parameter int WIDTH = HSR_WIDTH,
  parameter int DEPTH = HSR_FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pins from the driving logic
  input wire logic falling_edge_clock,
  input wire logic load_select,
  input wire logic serial_in,
  input wire logic [WIDTH-1:0] parallel_in,
  input wire logic output_drive_enable,
  // drain stall and capture status
  input wire logic stage_hold,
  output logic capture_ready,
  output logic stage_known,
  // three-state outputs
  output logic [WIDTH-1:0] tristate_out,
  output logic [WIDTH-1:0] tristate_oe
);
  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [HSR_PIN_W-1:0] pin_s1_q, pin_s2_q, pin_s3_q;
  logic [HSR_PIN_W-1:0] pin_now;
  logic clk_lvl_q, clk_lvl_d, oe_lvl_q, oe_lvl_d;
  logic clk_agree, oe_agree, fall_evt;

  assign pin_now = {falling_edge_clock, load_select, serial_in,
                    parallel_in, output_drive_enable};
  assign clk_agree = pin_s2_q[HSR_PIN_CLK_BIT] == pin_s3_q[HSR_PIN_CLK_BIT];
  assign oe_agree = pin_s2_q[HSR_PIN_OE_BIT] == pin_s3_q[HSR_PIN_OE_BIT];

  always_comb begin
    clk_lvl_d = clk_agree ? pin_s3_q[HSR_PIN_CLK_BIT] : clk_lvl_q;
    oe_lvl_d = oe_agree ? pin_s3_q[HSR_PIN_OE_BIT] : oe_lvl_q;
  end

  // edge-only sampling
  // the command is taken from the third stage at the filtered falling edge
  assign fall_evt = clk_lvl_q && !clk_lvl_d;

  always_ff @(posedge clk) begin
    if (rst) begin
      pin_s1_q <= HSR_PIN_RST;
      pin_s2_q <= HSR_PIN_RST;
      pin_s3_q <= HSR_PIN_RST;
      clk_lvl_q <= HSR_CLK_LVL_RST;
      oe_lvl_q <= HSR_OE_LVL_RST;
    end else begin
      pin_s1_q <= pin_now;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      clk_lvl_q <= clk_lvl_d;
      oe_lvl_q <= oe_lvl_d;
    end
  end

  // ****************************************
  // command FIFO
  // ****************************************
  logic [HSR_CMD_W-1:0] cmd_in, cmd_out;
  logic cmd_in_ready, cmd_valid, cmd_pop;

  assign cmd_in = pin_s3_q[HSR_PIN_CMD_LSB +: HSR_CMD_W];
  // a stalled drain lets edges queue up; a full queue drops new edges
  assign cmd_pop = cmd_valid && !stage_hold;

  hsr_fifo #(
    .W(HSR_CMD_W),
    .D(DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(fall_evt),
    .in_ready(cmd_in_ready),
    .in_data(cmd_in),
    .out_valid(cmd_valid),
    .out_ready(!stage_hold),
    .out_data(cmd_out)
  );

  // ****************************************
  // register stages
  // ****************************************
  logic [WIDTH-1:0] stage_bits_q, stage_bits_d;
  logic known_q, known_d;
  logic [WIDTH-1:0] out_q, out_d, oe_q, oe_d;
  logic ready_q;

  always_comb begin
    stage_bits_d = stage_bits_q;
    known_d = known_q || cmd_pop;
    if (cmd_pop) begin
      if (cmd_out[HSR_CMD_LOAD_BIT]) begin
        stage_bits_d = cmd_out[WIDTH-1:0];
      end else begin
        stage_bits_d = {stage_bits_q[WIDTH-2:0], cmd_out[HSR_CMD_SER_BIT]};
      end
    end
    out_d = known_d ? stage_bits_d : HSR_OUT_RST;
    // output enable gates only the drivers
    oe_d = {WIDTH{oe_lvl_d}};
  end

  // stages run free of the enable
  // stage bits have no reset: the device has none, contents start unknown
  always_ff @(posedge clk) begin
    stage_bits_q <= stage_bits_d;
    if (rst) begin
      known_q <= 1'b0;
      out_q <= HSR_OUT_RST;
      oe_q <= HSR_OUT_RST;
      ready_q <= 1'b0;
    end else begin
      known_q <= known_d;
      out_q <= out_d;
      oe_q <= oe_d;
      ready_q <= cmd_in_ready;
    end
  end

  assign tristate_out = out_q;
  assign tristate_oe = oe_q;
  assign stage_known = known_q;
  assign capture_ready = ready_q;

  // ****************************************
  // assertions
  // ****************************************
  property p_load;
    @(posedge clk) disable iff (rst)
    cmd_pop && cmd_out[HSR_CMD_LOAD_BIT] |=>
      tristate_out == $past(cmd_out[WIDTH-1:0]);
  endproperty
  a_load: assert property (p_load)
    else $error("parallel load not seen on outputs");

  property p_shift;
    @(posedge clk) disable iff (rst)
    cmd_pop && !cmd_out[HSR_CMD_LOAD_BIT] && known_q |=>
      tristate_out == {$past(stage_bits_q[WIDTH-2:0]),
                       $past(cmd_out[HSR_CMD_SER_BIT])};
  endproperty
  a_shift: assert property (p_shift)
    else $error("shift right result wrong");

  property p_hold_between;
    @(posedge clk) disable iff (rst)
    !cmd_pop && known_q |=> $stable(stage_bits_q);
  endproperty
  a_hold_between: assert property (p_hold_between)
    else $error("stages changed without a clock edge");

  // the driver flop follows the filtered level one edge later
  property p_drive;
    @(posedge clk) disable iff (rst)
    oe_lvl_d |=> tristate_oe == {WIDTH{1'b1}};
  endproperty
  a_drive: assert property (p_drive)
    else $error("outputs not driven while enabled");

  property p_off;
    @(posedge clk) disable iff (rst)
    !oe_lvl_d |=> tristate_oe == '0;
  endproperty
  a_off: assert property (p_off)
    else $error("outputs driven while disabled");

  property p_indep;
    @(posedge clk) disable iff (rst)
    cmd_pop && cmd_out[HSR_CMD_LOAD_BIT] && !oe_lvl_d |=>
      tristate_out == $past(cmd_out[WIDTH-1:0]) && tristate_oe == '0;
  endproperty
  a_indep: assert property (p_indep)
    else $error("disabled outputs blocked register update");

  property p_unknown;
    @(posedge clk) disable iff (rst)
    !known_q |-> tristate_out == HSR_OUT_RST;
  endproperty
  a_unknown: assert property (p_unknown)
    else $error("outputs show data before first load");

  property p_edge_push;
    @(posedge clk) disable iff (rst)
    fall_evt && cmd_in_ready && !cmd_valid ##1 !stage_hold
      |-> cmd_pop && cmd_out == $past(cmd_in);
  endproperty
  a_edge_push: assert property (p_edge_push)
    else $error("falling edge not applied to stages");

  c_load: cover property (@(posedge clk) disable iff (rst)
    cmd_pop && cmd_out[HSR_CMD_LOAD_BIT]);
  c_shift: cover property (@(posedge clk) disable iff (rst)
    cmd_pop && !cmd_out[HSR_CMD_LOAD_BIT]);
  c_full: cover property (@(posedge clk) disable iff (rst) !cmd_in_ready);
  c_off_update: cover property (@(posedge clk) disable iff (rst)
    cmd_pop && !oe_lvl_q);
endmodule

// [tb/hsr_pins.sv]
// system-side model driving the register's clock, mode and data pins
`timescale 1ns/1ps
module hsr_pins
  import hsr_pkg::*;
(
  // clock
  input wire logic clk,
  // pins toward the register
  output logic pin_clk,
  output logic pin_load,
  output logic pin_ser,
  output logic [HSR_WIDTH-1:0] pin_par
);
  initial begin
    pin_clk = 1'b1;
    {pin_load, pin_ser, pin_par} = 6'h3f;
  end
  task automatic send(logic [HSR_CMD_W-1:0] cmd, bit slow);
    @(negedge clk);
    {pin_load, pin_ser, pin_par} = cmd;
    repeat (slow ? 6 : 3) @(negedge clk);
    pin_clk = 1'b0;
    repeat (3) @(negedge clk);
    pin_clk = 1'b1;
    @(negedge clk);
    // hold over: scramble so a stale value can never pass
    {pin_load, pin_ser, pin_par} = ~cmd;
  endtask
endmodule

// [tb/testbench.sv]
// self-checking bench for the four-bit shift register
`timescale 1ns/1ps
module testbench;
  import hsr_pkg::*;
  logic clk = 1'b0, rst = 1'b1, oe = 1'b0, hold = 1'b0;
  logic fclk, ld, ser, cap_rdy, known;
  logic [3:0] par, out, oe_v, st = 4'h0;
  logic [7:0] exp_q[$];
  logic [7:0] last = 8'h00, last_seen = 8'h00, seen;
  logic [31:0] rng = 32'h0031d039;
  int n_fail = 0, checks_done = 0, held = 0;
  always #2 clk = ~clk;
  hsr_pins hsr_pins_i(.clk(clk), .pin_clk(fclk), .pin_load(ld),
    .pin_ser(ser), .pin_par(par));
  hsr_shift_reg hsr_shift_reg_i(.clk(clk), .rst(rst),
    .falling_edge_clock(fclk), .load_select(ld), .serial_in(ser),
    .parallel_in(par), .output_drive_enable(oe), .stage_hold(hold),
    .capture_ready(cap_rdy), .stage_known(known), .tristate_out(out),
    .tristate_oe(oe_v));
  function automatic logic [31:0] xs(logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic check(string what, logic [7:0] e, logic [7:0] s);
    checks_done++;
    if (e !== s) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, e, s);
    end
  endtask
  // only a change of the outputs is a result worth noting
  function automatic void note();
    logic [7:0] e;
    e = {{4{oe}}, st};
    if (e !== last) begin
      exp_q.push_back(e);
      last = e;
    end
  endfunction
  task automatic edge_cmd(logic l, logic s, logic [3:0] p, bit slow);
    if (!(hold && held >= HSR_FIFO_DEPTH)) begin
      held += int'(hold);
      st = l ? p : {st[2:0], s};
      note();
    end
    hsr_pins_i.send({l, s, p}, slow);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // *****************
  // output watcher
  // *****************
  always @(negedge clk) begin
    seen = {oe_v, out};
    if (!rst && seen !== last_seen) begin
      if (exp_q.size() == 0)
        check("unexpected change", last_seen, seen);
      else
        check("outputs", exp_q.pop_front(), seen);
      last_seen = seen;
    end
  end
  initial begin
    #20000;
    n_fail++;
    conclude();
  end
  initial begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    check("hidden stages", 8'h00, {oe_v, out});
    oe = 1'b1;
    note();
    repeat (8) @(negedge clk);
    for (int i = 0; i < 12; i++) begin
      rng = xs(rng);
      edge_cmd(~i[0], rng[4], rng[3:0], i[1]);
    end
    check("stage_known", 8'h01, {7'h00, known});
    $display("test modes done");
    oe = 1'b0;
    note();
    repeat (8) @(negedge clk);
    edge_cmd(1'b1, 1'b0, 4'ha, 1'b0);
    edge_cmd(1'b0, 1'b1, 4'h0, 1'b0);
    oe = 1'b1;
    note();
    repeat (8) @(negedge clk);
    $display("test enable done");
    hold = 1'b1;
    for (int i = 0; i < 18; i++) begin
      rng = xs(rng);
      edge_cmd(rng[5], rng[4], rng[3:0], 1'b0);
    end
    check("capture_ready", 8'h00, {7'h00, cap_rdy});
    hold = 1'b0;
    for (int k = 0; k < 60 && exp_q.size() > 0; k++) @(negedge clk);
    check("queue drained", 8'h00, 8'(exp_q.size()));
    check("capture_ready", 8'h01, {7'h00, cap_rdy});
    $display("test fifo done");
    conclude();
  end
endmodule
